// *** hdl/gwr_defs.vh ***
`ifndef GWR_DEFS_VH
`define GWR_DEFS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define GWR_IDX_PA_DIR 8'h02
`define GWR_IDX_PA_DATA 8'h03
`define GWR_IDX_PB_DIR 8'h05
`define GWR_IDX_PB_DATA 8'h06
`define GWR_IDX_SPK_CTRL 8'h12
`define GWR_IDX_WT_CTRL 8'h16
`define GWR_IDX_WT_KEY 8'h1d
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define GWR_SPK_EN_BIT 0
`define GWR_SPK_SENS_LO 1
`define GWR_SPK_FLAG_BIT 3
`define GWR_WT_SEL_LO 0
`define GWR_WT_EN_BIT 2
`define GWR_WT_FLAG_BIT 3
`define GWR_CARRIER_BIT 3
`define GWR_RST_NIBBLE 4'h0
`define GWR_CLEAR_KEY 4'ha
`define GWR_WAKE_VECTOR 12'h004
// ----------------------------------------
// Timing
// ----------------------------------------
`define GWR_PCLK_HZ 250000000
`define GWR_LRO_HZ 100000
`define GWR_CARRIER_HZ 38000
`define GWR_WT_P0_MS 1
`define GWR_WT_P1_MS 16
`define GWR_WT_P2_MS 64
`define GWR_WT_P3_MS 128
`define GWR_MS_PER_S 1000
`define GWR_CAR_HALF (`GWR_PCLK_HZ / (2 * `GWR_CARRIER_HZ))
`endif

// *** hdl/gwr_top.v ***
// How it works
// - Speaker wake armed only while halted
// - Armed speaker wake grounds both audio pins
// - Negative pin above reference wakes from halt
// - Bit0 enables speaker wake, bits2:1 sensitivity
// - Enabled wake timer counts in all modes
// - Timer overflow in halt wakes to vector
// - Overflow sets sticky timer flag
// - Period select picks 1/16/64/128 ms
// - Writing key A clears timer counter
// - Timer counts low-rate oscillator ticks
// - Four sources assert system reset
// - Reset during halt returns to normal
// - Direction bit one means output, reset zero
// - Output pin reads latch, no pull-down
// - Input pin reads pin, optional pull-down
// - Rising edge on enabled pin wakes
// - Double-edge option adds falling edges
// - Carrier option sends 38 kHz on pin3 while its latch bit is one
// - Carrier option forces pin3 low in halt
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "gwr_defs.vh"

module gwr_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire halt_request,
  input wire power_on_reset_n,
  input wire low_voltage_reset,
  input wire external_reset_n,
  input wire watchdog_overflow,
  input wire [3:0] port_a_wake_option,
  input wire [3:0] port_b_wake_option,
  input wire double_edge_wake_option,
  input wire carrier_option,
  input wire pull_down_option,
  input wire [3:0] port_a_in,
  input wire [3:0] port_b_in,
  input wire low_rate_oscillator,
  input wire audio_pulse_pos,
  input wire audio_pulse_neg,
  input wire speaker_wake_level,
  output reg [3:0] port_a_out,
  output reg [3:0] port_a_oe,
  output reg [3:0] port_a_pull_down,
  output reg [3:0] port_b_out,
  output reg [3:0] port_b_oe,
  output reg [3:0] port_b_pull_down,
  output reg audio_out_pos,
  output reg audio_out_neg,
  output reg [1:0] wake_sensitivity_select,
  output reg speaker_wake_armed,
  output reg halt_mode,
  output reg wake_pulse,
  output reg [11:0] wake_vector,
  output reg system_reset_n
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Per bit: output pins read latch, input pins read pin
  function [3:0] read_mix;
    input [3:0] dir;
    input [3:0] latch;
    input [3:0] pin;
    begin
      read_mix = (dir & latch) | (~dir & pin);
    end
  endfunction

  // Overflow tick count for a period select
  function [13:0] period_ticks;
    input [1:0] sel;
    reg [31:0] ms;
    reg [31:0] ticks;
    begin
      case (sel)
        2'h0: ms = `GWR_WT_P0_MS;
        2'h1: ms = `GWR_WT_P1_MS;
        2'h2: ms = `GWR_WT_P2_MS;
        default: ms = `GWR_WT_P3_MS;
      endcase
      ticks = ms * (`GWR_LRO_HZ / `GWR_MS_PER_S);
      period_ticks = ticks[13:0];
    end
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [3:0] port_a_dir; // Port A direction
  reg [3:0] port_a_value; // Port A latch
  reg [3:0] port_b_dir; // Port B direction
  reg [3:0] port_b_value; // Port B latch
  reg speaker_wake_enable; // Speaker wake enable
  reg speaker_wake_flag; // Speaker wake event seen
  reg wake_timer_enable; // Timer enable
  reg [1:0] wake_timer_period_select; // Timer period
  reg wake_timer_overflow_flag; // Timer overflow seen
  reg [3:0] timer_clear_key_reg; // Last key written

  // Internal state
  reg [3:0] port_a_prev; // Previous Port A pins
  reg [3:0] port_b_prev; // Previous Port B pins
  reg lro_prev; // Previous oscillator level
  reg [13:0] wt_count; // Timer tick count
  reg [11:0] car_count; // Carrier half-period count
  reg car_phase; // Carrier square wave
  wire [31:0] car_last = `GWR_CAR_HALF - 1; // Last count of a half period
  reg spk_level; // Sampled speaker comparator

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [7:0] reg_idx = {2'h0, paddr[7:2]}; // Word index
  wire access = psel & penable; // Access phase
  wire bus_commit = access & pready; // Transfer completes
  wire wr_en = bus_commit & pwrite; // Write commit
  wire [3:0] wd = pwdata[3:0]; // Write nibble

  // Register hits
  wire hit_pa_dir = (reg_idx == `GWR_IDX_PA_DIR);
  wire hit_pa_data = (reg_idx == `GWR_IDX_PA_DATA);
  wire hit_pb_dir = (reg_idx == `GWR_IDX_PB_DIR);
  wire hit_pb_data = (reg_idx == `GWR_IDX_PB_DATA);
  wire hit_spk = (reg_idx == `GWR_IDX_SPK_CTRL);
  wire hit_wt = (reg_idx == `GWR_IDX_WT_CTRL);
  wire hit_key = (reg_idx == `GWR_IDX_WT_KEY);
  wire hit_any = hit_pa_dir | hit_pa_data | hit_pb_dir | hit_pb_data
                 | hit_spk | hit_wt | hit_key;
  wire aligned = (paddr[1:0] == 2'h0); // Word aligned

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  wire any_reset_src = ~power_on_reset_n | low_voltage_reset
                       | ~external_reset_n | watchdog_overflow;
  wire [3:0] a_rise = port_a_in & ~port_a_prev;
  wire [3:0] a_fall = ~port_a_in & port_a_prev;
  wire [3:0] b_rise = port_b_in & ~port_b_prev;
  wire [3:0] b_fall = ~port_b_in & port_b_prev;
  wire [3:0] a_edge = a_rise | ({4{double_edge_wake_option}} & a_fall);
  wire [3:0] b_edge = b_rise | ({4{double_edge_wake_option}} & b_fall);
  wire pin_wake = |(port_a_wake_option & a_edge)
                  | |(port_b_wake_option & b_edge);
  wire spk_wake = speaker_wake_armed & spk_level;
  wire lro_tick = low_rate_oscillator & ~lro_prev;
  wire key_clear = wr_en & hit_key & (wd == `GWR_CLEAR_KEY);
  wire [13:0] wt_limit = period_ticks(wake_timer_period_select);
  wire wt_overflow = wake_timer_enable & lro_tick & ~key_clear
                     & (wt_count >= wt_limit - 14'h1);
  wire wake_event = halt_mode & (pin_wake | spk_wake | wt_overflow);

  // ----------------------------------------
  // APB slave handshake and read data
  // ----------------------------------------

  // One wait state: pready rises the cycle after penable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (access & ~pready)
    begin
      // Answer prepared during the wait state
      pready <= 1'b1;
      pslverr <= ~(hit_any & aligned);
      prdata <= 32'h0;
      if (!pwrite & aligned)
      begin
        case (reg_idx)
          `GWR_IDX_PA_DIR: prdata[3:0] <= port_a_dir;
          `GWR_IDX_PA_DATA: prdata[3:0] <= read_mix(port_a_dir, port_a_value,
                                                    port_a_in);
          `GWR_IDX_PB_DIR: prdata[3:0] <= port_b_dir;
          `GWR_IDX_PB_DATA: prdata[3:0] <= read_mix(port_b_dir, port_b_value,
                                                    port_b_in);
          `GWR_IDX_SPK_CTRL: prdata[3:0] <= {speaker_wake_flag,
                                             wake_sensitivity_select,
                                             speaker_wake_enable};
          `GWR_IDX_WT_CTRL: prdata[3:0] <= {wake_timer_overflow_flag,
                                            wake_timer_enable,
                                            wake_timer_period_select};
          `GWR_IDX_WT_KEY: prdata[3:0] <= timer_clear_key_reg;
          default: prdata <= 32'h0;
        endcase
      end
    end
    else
    begin
      // Drop answer after the commit edge
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------

  // Writes land only at the commit edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_a_dir <= `GWR_RST_NIBBLE;
      port_b_dir <= `GWR_RST_NIBBLE;
      port_a_value <= `GWR_RST_NIBBLE;
      port_b_value <= `GWR_RST_NIBBLE;
      speaker_wake_enable <= 1'b0;
      wake_sensitivity_select <= 2'h0;
      wake_timer_enable <= 1'b0;
      wake_timer_period_select <= 2'h0;
      timer_clear_key_reg <= `GWR_RST_NIBBLE;
    end
    else if (wr_en & aligned)
    begin
      if (hit_pa_dir)
        port_a_dir <= wd;
      if (hit_pa_data)
        port_a_value <= wd;
      if (hit_pb_dir)
        port_b_dir <= wd;
      if (hit_pb_data)
        port_b_value <= wd;
      if (hit_spk)
      begin
        speaker_wake_enable <= wd[`GWR_SPK_EN_BIT];
        wake_sensitivity_select <= wd[`GWR_SPK_SENS_LO +: 2];
      end
      if (hit_wt)
      begin
        wake_timer_enable <= wd[`GWR_WT_EN_BIT];
        wake_timer_period_select <= wd[`GWR_WT_SEL_LO +: 2];
      end
      if (hit_key)
        timer_clear_key_reg <= wd;
    end
  end

  // ----------------------------------------
  // Sticky flags: writing zero clears, event wins
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speaker_wake_flag <= 1'b0;
      wake_timer_overflow_flag <= 1'b0;
    end
    else
    begin
      // Speaker wake flag
      if (spk_wake)
        speaker_wake_flag <= 1'b1;
      else if (wr_en & aligned & hit_spk & ~wd[`GWR_SPK_FLAG_BIT])
        speaker_wake_flag <= 1'b0;
      // Timer overflow flag
      if (wt_overflow)
        wake_timer_overflow_flag <= 1'b1;
      else if (wr_en & aligned & hit_wt & ~wd[`GWR_WT_FLAG_BIT])
        wake_timer_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wake timer
  // ----------------------------------------

  // Counts oscillator rising edges in normal and halt
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lro_prev <= 1'b0;
      wt_count <= 14'h0;
    end
    else
    begin
      lro_prev <= low_rate_oscillator;
      if (!wake_timer_enable | key_clear)
        wt_count <= 14'h0;
      else if (wt_overflow)
        wt_count <= 14'h0;
      else if (lro_tick)
        wt_count <= wt_count + 14'h1;
    end
  end

  // ----------------------------------------
  // Halt, wake and system reset
  // ----------------------------------------

  // Halt entry, wake exit, reset forces normal mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halt_mode <= 1'b0;
      wake_pulse <= 1'b0;
      wake_vector <= 12'h0;
      system_reset_n <= 1'b0;
      speaker_wake_armed <= 1'b0;
    end
    else
    begin
      system_reset_n <= ~any_reset_src;
      wake_pulse <= wake_event & ~any_reset_src;
      if (any_reset_src)
        halt_mode <= 1'b0;
      else if (wake_event)
      begin
        halt_mode <= 1'b0;
        wake_vector <= `GWR_WAKE_VECTOR;
      end
      else if (halt_request)
        halt_mode <= 1'b1;
      // Armed only in halt, dropped as soon as halt ends
      speaker_wake_armed <= speaker_wake_enable & halt_mode
                            & ~wake_event & ~any_reset_src;
    end
  end

  // ----------------------------------------
  // Speaker path
  // ----------------------------------------

  // Comparator sample and audio pin drive
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spk_level <= 1'b0;
      audio_out_pos <= 1'b0;
      audio_out_neg <= 1'b0;
    end
    else
    begin
      spk_level <= speaker_wake_level;
      if (speaker_wake_armed)
      begin
        audio_out_pos <= 1'b0;
        audio_out_neg <= 1'b0;
      end
      else
      begin
        audio_out_pos <= audio_pulse_pos;
        audio_out_neg <= audio_pulse_neg;
      end
    end
  end

  // ----------------------------------------
  // Carrier generator
  // ----------------------------------------

  // Free-running square wave near 38 kHz
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      car_count <= 12'h0;
      car_phase <= 1'b0;
    end
    else if (car_count >= car_last[11:0])
    begin
      car_count <= 12'h0;
      car_phase <= ~car_phase;
    end
    else
      car_count <= car_count + 12'h1;
  end

  // ----------------------------------------
  // Port pins
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      // Per-bit pin drive, enable and pull-down
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          port_a_out[gi] <= 1'b0;
          port_a_oe[gi] <= 1'b0;
          port_a_pull_down[gi] <= 1'b0;
          port_b_out[gi] <= 1'b0;
          port_b_oe[gi] <= 1'b0;
          port_b_pull_down[gi] <= 1'b0;
          port_a_prev[gi] <= 1'b0;
          port_b_prev[gi] <= 1'b0;
        end
        else
        begin
          port_a_prev[gi] <= port_a_in[gi];
          port_b_prev[gi] <= port_b_in[gi];
          port_a_oe[gi] <= port_a_dir[gi];
          port_b_oe[gi] <= port_b_dir[gi];
          port_a_pull_down[gi] <= ~port_a_dir[gi] & pull_down_option;
          port_b_pull_down[gi] <= ~port_b_dir[gi] & pull_down_option;
          port_b_out[gi] <= port_b_value[gi];
          if ((gi == `GWR_CARRIER_BIT) && carrier_option)
          begin
            // Carrier pin: low in halt, else gated carrier
            if (halt_mode)
              port_a_out[gi] <= 1'b0;
            else
              port_a_out[gi] <= port_a_value[gi] & car_phase;
          end
          else
            port_a_out[gi] <= port_a_value[gi];
        end
      end
    end
  endgenerate

endmodule

// *** test/gwr_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module gwr_properties
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire halt_mode,
  input wire speaker_wake_armed,
  input wire speaker_wake_level,
  input wire audio_out_pos,
  input wire audio_out_neg,
  input wire wake_pulse,
  input wire carrier_option,
  input wire [3:0] port_a_out,
  input wire [3:0] port_a_oe,
  input wire [3:0] port_a_pull_down,
  input wire power_on_reset_n,
  input wire low_voltage_reset,
  input wire external_reset_n,
  input wire watchdog_overflow,
  input wire system_reset_n
);
  // Any reset source active
  wire src = !power_on_reset_n || low_voltage_reset || !external_reset_n || watchdog_overflow;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_ARM_NORMAL: assert property (!halt_mode |=> !speaker_wake_armed)
    else $error("armed outside halt");
  AST_AUDIO_GND: assert property (speaker_wake_armed |=> !audio_out_pos && !audio_out_neg)
    else $error("audio pins not grounded");
  AST_SPK_WAKE: assert property (halt_mode && speaker_wake_armed && speaker_wake_level
    |-> ##[1:4] wake_pulse) else $error("no speaker wake");
  AST_PULL_OFF: assert property ((port_a_oe & port_a_pull_down) == 4'h0)
    else $error("pull-down on output pin");
  AST_CARRIER_HALT: assert property (carrier_option && $past(carrier_option, 2) && halt_mode
    && $past(halt_mode) && $past(halt_mode, 2) |-> !port_a_out[3]) else $error("pin3 not low");
  AST_WAKE_EXIT: assert property (wake_pulse |-> !halt_mode && $past(halt_mode))
    else $error("wake outside halt");
  AST_RESET_SRC: assert property (src |=> !system_reset_n)
    else $error("system reset missing");
  AST_RESET_HALT: assert property (src |=> !halt_mode)
    else $error("halt kept over reset");
  cover property (speaker_wake_armed && speaker_wake_level);
  cover property (wake_pulse);
  cover property (pready && pslverr);
endmodule

// *** test/gwr_pins.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Pins, oscillator and speaker model
// ----------------------------------------
module gwr_pins
#(
  parameter integer LRO_HALF_NS = 5000
)
(
  input wire [3:0] port_a_out,
  input wire [3:0] port_a_oe,
  input wire [3:0] port_b_out,
  input wire [3:0] port_b_oe,
  input wire [3:0] ext_a,
  input wire [3:0] ext_b,
  input wire sound,
  input wire audio_out_neg,
  output wire [3:0] port_a_in,
  output wire [3:0] port_b_in,
  output logic low_rate_oscillator,
  output wire speaker_wake_level
);
  // Driven pins show the chip, others the outside level
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_a);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
  // Comparator: sound lifts the grounded negative pin
  assign speaker_wake_level = sound && !audio_out_neg;
  // Free-running low-rate clock
  initial low_rate_oscillator = 1'b0;
  always #(LRO_HALF_NS) low_rate_oscillator = ~low_rate_oscillator;
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "gwr_defs.vh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, halt_request = 0;
  logic power_on_reset_n = 1, low_voltage_reset = 0, external_reset_n = 1;
  logic watchdog_overflow = 0, double_edge_wake_option = 0, carrier_option = 0, sound = 0;
  logic pull_down_option = 1, audio_pulse_pos = 0, audio_pulse_neg = 0, b;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] port_a_wake_option = 0, port_b_wake_option = 0, ext_a = 0, ext_b = 0, d, v, e;
  wire [31:0] prdata;
  wire pready, pslverr, low_rate_oscillator, speaker_wake_level, audio_out_pos, audio_out_neg;
  wire speaker_wake_armed, halt_mode, wake_pulse, system_reset_n;
  wire [3:0] port_a_in, port_b_in, port_a_out, port_a_oe, port_a_pull_down;
  wire [3:0] port_b_out, port_b_oe, port_b_pull_down;
  wire [1:0] wake_sensitivity_select;
  wire [11:0] wake_vector;
  int err_count = 0, comparisons = 0, n;
  logic [32:0] exp_q[$], msk_q[$];
  localparam [7:0] pad = `GWR_IDX_PA_DIR * 4, pav = `GWR_IDX_PA_DATA * 4;
  localparam [7:0] pbd = `GWR_IDX_PB_DIR * 4, pbv = `GWR_IDX_PB_DATA * 4;
  localparam [7:0] spk = `GWR_IDX_SPK_CTRL * 4, wtc = `GWR_IDX_WT_CTRL * 4;
  localparam [7:0] key = `GWR_IDX_WT_KEY * 4;
  always #2 pclk = ~pclk;
  gwr_top gwr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .halt_request, .power_on_reset_n, .low_voltage_reset, .external_reset_n,
    .watchdog_overflow, .port_a_wake_option, .port_b_wake_option, .double_edge_wake_option,
    .carrier_option, .pull_down_option, .port_a_in, .port_b_in, .low_rate_oscillator,
    .audio_pulse_pos, .audio_pulse_neg, .speaker_wake_level, .port_a_out, .port_a_oe,
    .port_a_pull_down, .port_b_out, .port_b_oe, .port_b_pull_down, .audio_out_pos,
    .audio_out_neg, .wake_sensitivity_select, .speaker_wake_armed, .halt_mode, .wake_pulse,
    .wake_vector, .system_reset_n);
  // Fast oscillator: ten pclk per tick keeps runs short
  gwr_pins #(.LRO_HALF_NS(20)) gwr_pins_i (.port_a_out, .port_a_oe, .port_b_out, .port_b_oe,
    .ext_a, .ext_b, .sound, .audio_out_neg, .port_a_in, .port_b_in, .low_rate_oscillator,
    .speaker_wake_level);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; expectation queued for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] ex, m);
    exp_q.push_back(ex);
    msk_q.push_back(m);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [3:0] x);
    apb(1, a, {28'h0, x}, 33'h0, 33'h1_0000_0000);
  endtask
  task rd(input logic [7:0] a, input logic [3:0] x);
    apb(0, a, 0, {29'h0, x}, {33{1'b1}});
  endtask
  task halt;
    halt_request <= 1;
    @(posedge pclk);
    halt_request <= 0;
    @(posedge pclk);
  endtask
  task wait_wake(input int lim);
    n = 0;
    while (wake_pulse !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task wait_flip;
    b = port_a_out[3];
    n = 0;
    while (port_a_out[3] === b && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Monitor: oldest note against each completed transfer
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      chk({pslverr, pwrite ? 32'h0 : prdata} & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h9326));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(pad, 0);
    rd(pbd, 0);
    rd(spk, 0);
    rd(wtc, 0);
    apb(0, 8'h04, 0, {1'b1, 32'h0}, {33{1'b1}});
    apb(1, 8'h49, 32'h1, {1'b1, 32'h0}, 33'h1_0000_0000);
    rd(spk, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      d = 4'($urandom);
      v = 4'($urandom);
      e = 4'($urandom);
      wr(i[0] ? pbd : pad, d);
      wr(i[0] ? pbv : pav, v);
      if (i[0]) ext_b <= e; else ext_a <= e;
      rd(i[0] ? pbv : pav, (d & v) | (~d & e));
      chk(i[0] ? port_b_oe : port_a_oe, d);
      chk(i[0] ? port_b_out : port_a_out, v);
      chk(i[0] ? port_b_pull_down : port_a_pull_down, {29'h0, ~d});
    end
    $display("test ports done");
    wr(pbd, 0);
    port_b_wake_option <= 4'h2;
    ext_b <= 4'h2;
    halt;
    ext_b <= 4'h0;
    repeat (10) @(posedge pclk);
    chk(halt_mode, 1);
    ext_b <= 4'h2;
    wait_wake(20);
    chk(n < 20, 1);
    @(posedge pclk);
    chk(wake_vector, 12'h004);
    double_edge_wake_option <= 1;
    halt;
    ext_b <= 4'h0;
    wait_wake(20);
    chk(n < 20, 1);
    double_edge_wake_option <= 0;
    $display("test pin wake done");
    for (int s = 0; s < 4; s++)
    begin
      wr(spk, 4'(s * 2));
      chk(wake_sensitivity_select, 33'(s));
    end
    wr(spk, 4'h5);
    audio_pulse_pos <= 1;
    audio_pulse_neg <= 1;
    repeat (3) @(posedge pclk);
    chk({audio_out_pos, audio_out_neg}, 2'b11);
    // Silence before halting; pin0 wake stays off
    audio_pulse_pos <= 0;
    audio_pulse_neg <= 0;
    repeat (20) @(posedge pclk);
    halt;
    audio_pulse_pos <= 1;
    audio_pulse_neg <= 1;
    repeat (3) @(posedge pclk);
    chk({audio_out_pos, audio_out_neg, speaker_wake_armed}, 3'b001);
    sound <= 1;
    wait_wake(20);
    chk(n < 20, 1);
    sound <= 0;
    audio_pulse_pos <= 0;
    audio_pulse_neg <= 0;
    rd(spk, 4'hd);
    wr(spk, 4'h5);
    rd(spk, 4'h5);
    wr(spk, 4'h0);
    $display("test speaker done");
    for (int s = 0; s < 4; s++)
    begin
      wr(wtc, 4'(s));
      rd(wtc, 4'(s));
    end
    wr(wtc, 4'h4);
    // Key mid-count: wake must come a full period after it
    repeat (500) @(posedge pclk);
    wr(key, `GWR_CLEAR_KEY);
    halt;
    wait_wake(1200);
    chk(n > 950 && n < 1030, 1);
    rd(wtc, 4'hc);
    wr(wtc, 4'h4);
    rd(wtc, 4'h4);
    repeat (1100) @(posedge pclk);
    rd(wtc, 4'hc);
    wr(wtc, 4'h0);
    repeat (1100) @(posedge pclk);
    rd(wtc, 4'h0);
    // Second period select: 1600 ticks of the fast oscillator
    wr(wtc, 4'h5);
    wr(key, `GWR_CLEAR_KEY);
    halt;
    wait_wake(16500);
    chk(n > 15900 && n < 16010, 1);
    wr(wtc, 4'h0);
    $display("test timer done");
    carrier_option <= 1;
    wr(pad, 4'h8);
    wr(pav, 4'h8);
    wait_flip;
    wait_flip;
    chk(n, `GWR_CAR_HALF);
    halt;
    repeat (3) @(posedge pclk);
    chk(port_a_out[3], 0);
    ext_b <= 4'h2;
    wait_wake(20);
    chk(n < 20, 1);
    wr(pav, 4'h0);
    repeat (3) @(posedge pclk);
    chk(port_a_out[3], 0);
    carrier_option <= 0;
    $display("test carrier done");
    for (int k = 0; k < 4; k++)
    begin
      halt;
      {power_on_reset_n, low_voltage_reset, external_reset_n, watchdog_overflow} <=
        {k != 0, k == 1, k != 2, k == 3};
      @(posedge pclk);
      {power_on_reset_n, low_voltage_reset, external_reset_n, watchdog_overflow} <= 4'b1010;
      @(posedge pclk);
      chk({system_reset_n, halt_mode}, 2'b00);
      repeat (3) @(posedge pclk);
    end
    $display("test reset sources done");
    close_out;
  end
  // Hang guard
  initial
  begin
    #400000;
    err_count++;
    close_out;
  end
endmodule
bind gwr_top gwr_properties gwr_properties_i (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .halt_mode, .speaker_wake_armed, .speaker_wake_level, .audio_out_pos,
  .audio_out_neg, .wake_pulse, .carrier_option, .port_a_out, .port_a_oe, .port_a_pull_down,
  .power_on_reset_n, .low_voltage_reset, .external_reset_n, .watchdog_overflow,
  .system_reset_n);
